// ==== pkg/sdpr_defines.svh ====
// Purpose: Constants for the dual-port RAM port logic
// Assumes: One system clock of 250 MHz for both ports
// Notes:   Times are in ps; cycle counts derive from them
`ifndef SDPR_DEFINES_SVH
`define SDPR_DEFINES_SVH

// ****************************************************************
// Array geometry
// ****************************************************************
`define SDPR_ADDR_W        16
`define SDPR_DATA_W        18
`define SDPR_LANE_W        9
`define SDPR_LANES         2
`define SDPR_LANE_LOWER    0
`define SDPR_LANE_UPPER    1
`define SDPR_ADDR_ZERO     16'h0000

// ****************************************************************
// Reset values
// ****************************************************************
`define SDPR_LANE_N_RST    2'h3
`define SDPR_OE_N_RST      1'h1

// ****************************************************************
// Timing
// ****************************************************************
`define SDPR_CLK_PS        4000
`define SDPR_TCWDD_PS      28000
`define SDPR_TCCS_PS       10000
`define SDPR_FLOWTHROUGH_ACCESS_TIME_PS       18000
// Longest times round up, least times round down
`define SDPR_TCWDD_CYC ((`SDPR_TCWDD_PS + `SDPR_CLK_PS - 1) / `SDPR_CLK_PS)
`define SDPR_TCCS_CYC  (`SDPR_TCCS_PS / `SDPR_CLK_PS)
`define SDPR_FLOWTHROUGH_ACCESS_TIME_CYC  ((`SDPR_FLOWTHROUGH_ACCESS_TIME_PS + `SDPR_CLK_PS - 1) / `SDPR_CLK_PS)
`define SDPR_BUSY_W        4

`endif

// ==== pkg/sdpr_pkg.sv ====
// Purpose: Types shared by the dual-port RAM port logic
// Assumes: Nothing beyond the defines header
// Notes:   Constants live in sdpr_defines.svh
package sdpr_pkg;

  // ****************************************************************
  // Output timing mode of one port
  // ****************************************************************
  typedef enum logic
  {
    SDPR_MODE_FLOW = 1'b0,
    SDPR_MODE_PIPE = 1'b1
  } sdpr_mode_t;

endpackage : sdpr_pkg

// ==== design/sdpr_port_front.sv ====
// Purpose: Input registers and address counter of one RAM port
// Assumes: Control pins are synchronous to clk_sys except the
//          output enable and the mode select
// Notes:   Counter priority is clear, load, advance, hold
`timescale 1ns/1ps
`include "sdpr_defines.svh"

module sdpr_port_front #(
  parameter int ADDR_W = `SDPR_ADDR_W,
  parameter int DATA_W = `SDPR_DATA_W
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Pins of the port
  input  wire logic              chip_select_low_active_n,
  input  wire logic              chip_select_high_active,
  input  wire logic              read_write,
  input  wire logic              upper_lane_select_n,
  input  wire logic              lower_lane_select_n,
  input  wire logic              address_load_strobe_n,
  input  wire logic              counter_advance_n,
  input  wire logic              counter_clear_n,
  input  wire logic              output_enable_n,
  input  wire logic              output_mode_select,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] dq_in,
  // Registered view of the port
  output logic      [ADDR_W-1:0] addr_r,
  output logic                   sel_r,
  output logic                   rd_r,
  output logic      [1:0]        lane_n_r,
  output logic      [DATA_W-1:0] wdata_r,
  output logic                   oe_n_s_r,
  output sdpr_pkg::sdpr_mode_t   mode_s_r
);

  logic oe_n_meta_r;
  logic mode_meta_r;

  // ****************************************************************
  // Two-stage capture of the unclocked pins
  // ****************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      oe_n_meta_r <= `SDPR_OE_N_RST;
      oe_n_s_r    <= `SDPR_OE_N_RST;
      mode_meta_r <= 1'h0;
      mode_s_r    <= sdpr_pkg::SDPR_MODE_FLOW;
    end
    else
    begin
      oe_n_meta_r <= output_enable_n;
      oe_n_s_r    <= oe_n_meta_r;
      mode_meta_r <= output_mode_select;
      mode_s_r    <= sdpr_pkg::sdpr_mode_t'(mode_meta_r);
    end
  end

  // ****************************************************************
  // Address counter
  // ****************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      addr_r <= `SDPR_ADDR_ZERO;
    else if (!counter_clear_n)
      addr_r <= `SDPR_ADDR_ZERO;
    else if (!address_load_strobe_n)
      addr_r <= addr;
    else if (!counter_advance_n)
      addr_r <= addr_r + ADDR_W'(1);
    else
      addr_r <= addr_r;
  end

  // ****************************************************************
  // Control and data input registers
  // ****************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sel_r    <= 1'h0;
      rd_r     <= 1'h1;
      lane_n_r <= `SDPR_LANE_N_RST;
      wdata_r  <= '0;
    end
    else
    begin
      sel_r    <= !chip_select_low_active_n &&
                  chip_select_high_active;
      rd_r     <= read_write;
      lane_n_r <= {upper_lane_select_n, lower_lane_select_n};
      wdata_r  <= dq_in;
    end
  end

endmodule : sdpr_port_front

// ==== design/sdpr_dual_port_ram.sv ====
// Behaviour
// - Mode select high pipelined, low flow-through, per port
// - Inputs sampled on clock; enable, mode unclocked
// - Lane off floats data next edge; deselect does in flow-through, one edge later in pipelined
// - Unselected lane floats, selected lane still driven
// - Load strobe low takes external address each edge
// - Peer read waits write-to-read delay after write
// - Late read clock adds lag plus access time
// - Output state follows previous cycle's controls
// - Both ports identical and symmetric; here port B wins a same-word write collision
// - Pipelined read data one cycle after flow-through
// - Counter advance low increments address, ignores selects
// - Counter clear low zeroes address, overrides all
// - Pipelined chip selects two stages, flow-through one
//
// Purpose: Two-port synchronous RAM with per-port counters
// Assumes: Both ports run on clk_sys; controllers are synchronous
// Notes:   Output enable and mode pass a two-stage synchroniser
`timescale 1ns/1ps
`include "sdpr_defines.svh"

module sdpr_dual_port_ram #(
  parameter int ADDR_W = `SDPR_ADDR_W,
  parameter int LANE_W = `SDPR_LANE_W,
  parameter int DEPTH  = 1 << `SDPR_ADDR_W
) (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  // Port A controls
  input  wire logic                 a_chip_select_low_active_n,
  input  wire logic                 a_chip_select_high_active,
  input  wire logic                 a_read_write,
  input  wire logic                 a_upper_lane_select_n,
  input  wire logic                 a_lower_lane_select_n,
  input  wire logic                 a_address_load_strobe_n,
  input  wire logic                 a_counter_advance_n,
  input  wire logic                 a_counter_clear_n,
  input  wire logic                 a_output_enable_n,
  input  wire logic                 a_output_mode_select,
  // Port A address and data
  input  wire logic [ADDR_W-1:0]    a_addr,
  input  wire logic [2*LANE_W-1:0]  a_dq_in,
  output logic      [2*LANE_W-1:0]  a_dq_out,
  output logic      [1:0]           a_dq_oe,
  output logic                      a_peer_write_busy,
  // Port B controls
  input  wire logic                 b_chip_select_low_active_n,
  input  wire logic                 b_chip_select_high_active,
  input  wire logic                 b_read_write,
  input  wire logic                 b_upper_lane_select_n,
  input  wire logic                 b_lower_lane_select_n,
  input  wire logic                 b_address_load_strobe_n,
  input  wire logic                 b_counter_advance_n,
  input  wire logic                 b_counter_clear_n,
  input  wire logic                 b_output_enable_n,
  input  wire logic                 b_output_mode_select,
  // Port B address and data
  input  wire logic [ADDR_W-1:0]    b_addr,
  input  wire logic [2*LANE_W-1:0]  b_dq_in,
  output logic      [2*LANE_W-1:0]  b_dq_out,
  output logic      [1:0]           b_dq_oe,
  output logic                      b_peer_write_busy
);

  localparam int DATA_W = 2 * LANE_W;
  localparam int NPORT  = 2;
  localparam int BUSY_W = `SDPR_BUSY_W;
  localparam int WAIT_A = `SDPR_TCWDD_CYC;
  localparam int WAIT_B = `SDPR_TCCS_CYC + `SDPR_FLOWTHROUGH_ACCESS_TIME_CYC;
  localparam logic [BUSY_W-1:0] BUSY_CYC =
    BUSY_W'((WAIT_A > WAIT_B) ? WAIT_A : WAIT_B);

  // ****************************************************************
  // Storage and per-port registered views
  // ****************************************************************
  logic [DATA_W-1:0]     mem [0:DEPTH-1];

  logic [ADDR_W-1:0]     addr_r   [NPORT];
  logic                  sel_r    [NPORT];
  logic                  rd_r     [NPORT];
  logic [1:0]            lane_n_r [NPORT];
  logic [DATA_W-1:0]     wdata_r  [NPORT];
  logic                  oe_n_s_r [NPORT];
  sdpr_pkg::sdpr_mode_t  mode_s_r [NPORT];

  logic [DATA_W-1:0]     s1_data_r  [NPORT];
  logic                  s1_rdsel_r [NPORT];
  logic [DATA_W-1:0]     dq_out_r   [NPORT];
  logic [1:0]            dq_oe_r    [NPORT];
  logic [BUSY_W-1:0]     busy_cnt_r [NPORT];
  logic                  busy_r     [NPORT];

  // ****************************************************************
  // Port front ends
  // ****************************************************************
  sdpr_port_front #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W)
  ) u_front_a (
    .clk_sys                  (clk_sys),
    .rst                      (rst),
    .chip_select_low_active_n (a_chip_select_low_active_n),
    .chip_select_high_active  (a_chip_select_high_active),
    .read_write               (a_read_write),
    .upper_lane_select_n      (a_upper_lane_select_n),
    .lower_lane_select_n      (a_lower_lane_select_n),
    .address_load_strobe_n    (a_address_load_strobe_n),
    .counter_advance_n        (a_counter_advance_n),
    .counter_clear_n          (a_counter_clear_n),
    .output_enable_n          (a_output_enable_n),
    .output_mode_select       (a_output_mode_select),
    .addr                     (a_addr),
    .dq_in                    (a_dq_in),
    .addr_r                   (addr_r[0]),
    .sel_r                    (sel_r[0]),
    .rd_r                     (rd_r[0]),
    .lane_n_r                 (lane_n_r[0]),
    .wdata_r                  (wdata_r[0]),
    .oe_n_s_r                 (oe_n_s_r[0]),
    .mode_s_r                 (mode_s_r[0])
  );

  // Same front end on the other side
  sdpr_port_front #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W)
  ) u_front_b (
    .clk_sys                  (clk_sys),
    .rst                      (rst),
    .chip_select_low_active_n (b_chip_select_low_active_n),
    .chip_select_high_active  (b_chip_select_high_active),
    .read_write               (b_read_write),
    .upper_lane_select_n      (b_upper_lane_select_n),
    .lower_lane_select_n      (b_lower_lane_select_n),
    .address_load_strobe_n    (b_address_load_strobe_n),
    .counter_advance_n        (b_counter_advance_n),
    .counter_clear_n          (b_counter_clear_n),
    .output_enable_n          (b_output_enable_n),
    .output_mode_select       (b_output_mode_select),
    .addr                     (b_addr),
    .dq_in                    (b_dq_in),
    .addr_r                   (addr_r[1]),
    .sel_r                    (sel_r[1]),
    .rd_r                     (rd_r[1]),
    .lane_n_r                 (lane_n_r[1]),
    .wdata_r                  (wdata_r[1]),
    .oe_n_s_r                 (oe_n_s_r[1]),
    .mode_s_r                 (mode_s_r[1])
  );

  // ****************************************************************
  // Array write, one edge after the inputs are registered
  // ****************************************************************
  // Same-word collision: port B is applied last and wins
  always_ff @(posedge clk_sys)
  begin
    for (int p = 0; p < NPORT; p++)
    begin
      if (sel_r[p] && !rd_r[p])
      begin
        for (int l = 0; l < `SDPR_LANES; l++)
        begin
          if (!lane_n_r[p][l])
            mem[addr_r[p]][l*LANE_W +: LANE_W] <=
              wdata_r[p][l*LANE_W +: LANE_W];
        end
      end
    end
  end

  // ****************************************************************
  // Read paths, output drivers and peer write window
  // ****************************************************************
  for (genvar p = 0; p < NPORT; p++)
  begin : g_port
    logic [DATA_W-1:0] rd_word;
    logic              rd_sel;

    assign rd_word = mem[addr_r[p]];
    assign rd_sel  = sel_r[p] && rd_r[p];

    // Extra stage for pipelined mode; chip select rides along
    always_ff @(posedge clk_sys)
    begin
      if (rst)
      begin
        s1_data_r[p]  <= '0;
        s1_rdsel_r[p] <= 1'h0;
      end
      else
      begin
        s1_data_r[p]  <= rd_word;
        s1_rdsel_r[p] <= rd_sel;
      end
    end

    // Lane selects stay single-staged in both modes
    always_ff @(posedge clk_sys)
    begin
      if (rst)
      begin
        dq_out_r[p] <= '0;
        dq_oe_r[p]  <= 2'h0;
      end
      else if (mode_s_r[p] == sdpr_pkg::SDPR_MODE_PIPE)
      begin
        dq_out_r[p] <= s1_data_r[p];
        for (int l = 0; l < `SDPR_LANES; l++)
          dq_oe_r[p][l] <= s1_rdsel_r[p] && !lane_n_r[p][l] &&
                           !oe_n_s_r[p];
      end
      else
      begin
        dq_out_r[p] <= rd_word;
        for (int l = 0; l < `SDPR_LANES; l++)
          dq_oe_r[p][l] <= rd_sel && !lane_n_r[p][l] &&
                           !oe_n_s_r[p];
      end
    end

    // Busy after a peer write for the longer of both settle windows
    always_ff @(posedge clk_sys)
    begin
      if (rst)
      begin
        busy_cnt_r[p] <= '0;
        busy_r[p]     <= 1'h0;
      end
      else if (sel_r[NPORT-1-p] && !rd_r[NPORT-1-p])
      begin
        busy_cnt_r[p] <= BUSY_CYC;
        busy_r[p]     <= 1'h1;
      end
      else if (busy_cnt_r[p] != '0)
      begin
        busy_cnt_r[p] <= busy_cnt_r[p] - BUSY_W'(1);
        busy_r[p]     <= (busy_cnt_r[p] != BUSY_W'(1));
      end
      else
      begin
        busy_cnt_r[p] <= busy_cnt_r[p];
        busy_r[p]     <= 1'h0;
      end
    end
  end

  // ****************************************************************
  // Output pins, each straight from a flip-flop
  // ****************************************************************
  assign a_dq_out          = dq_out_r[0];
  assign a_dq_oe           = dq_oe_r[0];
  assign a_peer_write_busy = busy_r[0];
  assign b_dq_out          = dq_out_r[1];
  assign b_dq_oe           = dq_oe_r[1];
  assign b_peer_write_busy = busy_r[1];

endmodule : sdpr_dual_port_ram

// ==== verification/sdpr_ram_monitor.sv ====
// Purpose: Port A and peer-window checks on the dual-port RAM
// Assumes: Both ports share clk_sys
// Notes:   Port B mirrors port A and is left to the bench
`timescale 1ns/1ps

module sdpr_ram_monitor (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // Port A pins
  input wire logic        a_chip_select_low_active_n,
  input wire logic        a_chip_select_high_active,
  input wire logic        a_read_write,
  input wire logic        a_upper_lane_select_n,
  input wire logic        a_lower_lane_select_n,
  input wire logic        a_address_load_strobe_n,
  input wire logic        a_counter_advance_n,
  input wire logic        a_counter_clear_n,
  input wire logic        a_output_enable_n,
  input wire logic [17:0] a_dq_out,
  input wire logic [1:0]  a_dq_oe,
  // Peer windows
  input wire logic        a_peer_write_busy,
  input wire logic        b_peer_write_busy
);
  wire a_sel = !a_chip_select_low_active_n && a_chip_select_high_active;
  wire a_wr = a_sel && !a_read_write;
  wire a_wrl = a_wr && !(a_upper_lane_select_n && a_lower_lane_select_n);
  wire a_rd = a_sel && a_read_write && !a_upper_lane_select_n
    && !a_lower_lane_select_n;
  wire a_hold = a_rd && a_address_load_strobe_n && a_counter_advance_n
    && a_counter_clear_n && !a_output_enable_n && !a_peer_write_busy;

  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  desel_float_a:
    assert property (!a_sel [*3] |=> a_dq_oe == 2'h0)
    else $error("Data driven after deselect");
  lane_float_a:
    assert property ((a_dq_oe & $past({a_upper_lane_select_n,
      a_lower_lane_select_n}, 2)) == 2'h0)
    else $error("Unselected lane driven");
  write_quiet_a:
    assert property (a_wr [*3] |=> a_dq_oe == 2'h0)
    else $error("Data driven during writes");
  oe_off_a:
    assert property (a_output_enable_n [*4] |=> a_dq_oe == 2'h0)
    else $error("Data driven with outputs disabled");
  read_drive_a:
    assert property ((!a_output_enable_n) [*2] ##1
      (!a_output_enable_n && a_rd) [*3] |=> a_dq_oe == 2'h3)
    else $error("Read lanes not driven");
  peer_busy_a:
    assert property (a_wrl |-> ##2 b_peer_write_busy [*7])
    else $error("Peer window too short");
  busy_ends_a:
    assert property (!a_wr [*8] |=> !b_peer_write_busy)
    else $error("Peer window too long");
  hold_data_a:
    assert property (a_hold [*4] |-> $stable(a_dq_out))
    else $error("Data moved while address held");

  cover property (a_wrl ##2 b_peer_write_busy);
  cover property (a_hold [*4]);
  cover property (a_rd ##1 a_dq_oe == 2'h3);
endmodule : sdpr_ram_monitor

bind sdpr_dual_port_ram sdpr_ram_monitor sdpr_ram_monitor_inst (
  .clk_sys, .rst, .a_chip_select_low_active_n, .a_chip_select_high_active,
  .a_read_write, .a_upper_lane_select_n, .a_lower_lane_select_n,
  .a_address_load_strobe_n, .a_counter_advance_n, .a_counter_clear_n,
  .a_output_enable_n, .a_dq_out, .a_dq_oe, .a_peer_write_busy,
  .b_peer_write_busy
);

// ==== verification/sdpr_ctrl_model.sv ====
// Purpose: Bus controller model for one RAM port
// Assumes: Pins change only on falling clock edges
// Notes:   Data lines toggle while not writing
`timescale 1ns/1ps

module sdpr_ctrl_model (
  // Clock
  input wire logic    clk_sys,
  // Pins toward the port
  output logic        cs_n = 1'h1,
  output logic        cs_h = 1'h0,
  output logic        rw = 1'h1,
  output logic [1:0]  lane_n = 2'h3,
  output logic        ld_n = 1'h1,
  output logic        adv_n = 1'h1,
  output logic        clr_n = 1'h1,
  output logic [15:0] addr = 16'h0,
  output logic [17:0] dq = 18'h0
);
  // One bus cycle; s is high select then low select
  task automatic cyc(input logic [1:0] s, input logic r,
    input logic [1:0] l, input logic [2:0] k, input logic [15:0] a,
    input logic [17:0] d);
    @(negedge clk_sys);
    {cs_h, cs_n} = s;
    rw = r;
    lane_n = l;
    {ld_n, adv_n, clr_n} = k;
    addr = a;
    dq = r ? ~dq : d;
    @(posedge clk_sys);
    #1;
  endtask : cyc
endmodule : sdpr_ctrl_model

// ==== verification/test_sync_dual_port_ram_port.sv ====
// Purpose: Bench for the dual-port RAM port logic
// Assumes: Controller models drive pins on falling edges
// Notes:   Ports swap writer and reader between the two modes
`timescale 1ns/1ps

module test_sync_dual_port_ram_port;
  localparam logic [2:0] LD = 3'h3;
  localparam logic [2:0] ADV = 3'h5;
  localparam logic [2:0] HOLD = 3'h7;
  localparam logic [2:0] CLR = 3'h0;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic [1:0] md = 2'h0;
  logic [1:0] oe_n = 2'h3;
  wire [1:0] cs_n, cs_h, rw, ld_n, adv_n, clr_n, busy;
  wire [1:0][1:0] ln, dq_oe;
  wire [1:0][15:0] ad;
  wire [1:0][17:0] di, dq_out;
  logic [17:0] d0, d1, d2, d3, e;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;
  int w, r;

  initial forever #2 clk_sys = ~clk_sys;

  sdpr_ctrl_model sdpr_ctrl_model_inst [1:0] (
    .clk_sys(clk_sys), .cs_n(cs_n), .cs_h(cs_h), .rw(rw), .lane_n(ln),
    .ld_n(ld_n), .adv_n(adv_n), .clr_n(clr_n), .addr(ad), .dq(di)
  );

  sdpr_dual_port_ram sdpr_dual_port_ram_inst (
    .clk_sys(clk_sys), .rst(rst),
    .a_chip_select_low_active_n(cs_n[0]), .a_read_write(rw[0]),
    .a_chip_select_high_active(cs_h[0]), .a_addr(ad[0]),
    .a_upper_lane_select_n(ln[0][1]), .a_lower_lane_select_n(ln[0][0]),
    .a_address_load_strobe_n(ld_n[0]), .a_counter_advance_n(adv_n[0]),
    .a_counter_clear_n(clr_n[0]), .a_output_enable_n(oe_n[0]),
    .a_output_mode_select(md[0]), .a_dq_in(di[0]), .a_dq_out(dq_out[0]),
    .a_dq_oe(dq_oe[0]), .a_peer_write_busy(busy[0]),
    .b_chip_select_low_active_n(cs_n[1]), .b_read_write(rw[1]),
    .b_chip_select_high_active(cs_h[1]), .b_addr(ad[1]),
    .b_upper_lane_select_n(ln[1][1]), .b_lower_lane_select_n(ln[1][0]),
    .b_address_load_strobe_n(ld_n[1]), .b_counter_advance_n(adv_n[1]),
    .b_counter_clear_n(clr_n[1]), .b_output_enable_n(oe_n[1]),
    .b_output_mode_select(md[1]), .b_dq_in(di[1]), .b_dq_out(dq_out[1]),
    .b_dq_oe(dq_oe[1]), .b_peer_write_busy(busy[1])
  );

  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic c(input int p, input logic [1:0] s, input logic rd,
    input logic [1:0] l, input logic [2:0] k, input logic [15:0] a);
    if (p == 1)
      sdpr_ctrl_model_inst[1].cyc(s, rd, l, k, a, d0);
    else
      sdpr_ctrl_model_inst[0].cyc(s, rd, l, k, a, d0);
  endtask : c

  task automatic stop_test;
    $display("Checks %0d, miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      miscompares++;
      stop_test();
    end
  end

  initial
  begin
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'h0;
    for (int m = 0; m < 2; m++)
    begin
      w = m;
      r = 1 - m;
      @(negedge clk_sys);
      md = {2{m[0]}};
      oe_n = 2'h0;
      repeat (4) c(w, 2'h1, 1'h1, 2'h3, HOLD, 16'h1234);
      d1 = 18'h2c3c3 ^ {18{m[0]}};
      d2 = 18'h0ff00 ^ {18{m[0]}};
      d3 = 18'h30f0f ^ {18{m[0]}};
      d0 = 18'h15a5a ^ {18{m[0]}};
      c(w, 2'h2, 1'h0, 2'h0, LD, 16'h0000);
      e = {d3[17:9], d2[8:0]};
      sdpr_write(d1, 16'h7ffe, 2'h0);
      sdpr_write(d2, 16'h7fff, 2'h0);
      sdpr_write(d3, 16'h7fff, 2'h1);
      d0 = 18'h15a5a ^ {18{m[0]}};
      c(w, 2'h1, 1'h1, 2'h3, HOLD, 16'h1234);
      chk(busy[r], 1'h1);
      chk(busy[w], 1'h0);
      repeat (6) c(w, 2'h1, 1'h1, 2'h3, HOLD, 16'h1234);
      chk(busy[r], 1'h1);
      c(w, 2'h1, 1'h1, 2'h3, HOLD, 16'h1234);
      chk(busy[r], 1'h0);
      c(r, 2'h2, 1'h1, 2'h0, LD, 16'h7ffe);
      c(r, 2'h2, 1'h1, 2'h0, ADV, 16'h1234);
      if (m == 0)
        chk(dq_out[r], d1);
      c(r, 2'h2, 1'h1, 2'h0, HOLD, 16'h1234);
      chk(dq_out[r], m ? d1 : e);
      c(r, 2'h2, 1'h1, 2'h0, HOLD, 16'h1234);
      chk(dq_out[r], e);
      chk(dq_oe[r], 2'h3);
      c(r, 2'h2, 1'h1, 2'h0, CLR, 16'h7ffe);
      repeat (4) c(r, 2'h2, 1'h1, 2'h0, HOLD, 16'h1234);
      chk(dq_out[r], d0);
      c(r, 2'h2, 1'h1, 2'h2, LD, 16'h7fff);
      repeat (2) c(r, 2'h2, 1'h1, 2'h2, HOLD, 16'h1234);
      chk(dq_oe[r], 2'h1);
      chk(dq_out[r] & 18'h001ff, e & 18'h001ff);
      c(r, 2'h3, 1'h1, 2'h2, HOLD, 16'h1234);
      c(r, 2'h0, 1'h1, 2'h2, HOLD, 16'h1234);
      chk(dq_oe[r], m ? 2'h1 : 2'h0);
      c(r, 2'h1, 1'h1, 2'h2, HOLD, 16'h1234);
      chk(dq_oe[r], 2'h0);
      @(negedge clk_sys);
      oe_n[r] = 1'h1;
      repeat (4) c(r, 2'h2, 1'h1, 2'h0, LD, 16'h7ffe);
      chk(dq_oe[r], 2'h0);
      c(r, 2'h1, 1'h1, 2'h3, HOLD, 16'h1234);
    end
    stop_test();
  end

  // Write one word through the writing port's model
  task automatic sdpr_write(input logic [17:0] x, input logic [15:0] a,
    input logic [1:0] l);
    d0 = x;
    c(w, 2'h2, 1'h0, l, LD, a);
  endtask : sdpr_write
endmodule : test_sync_dual_port_ram_port
